// File: seia_pkg.sv
// Purpose: Shared constants and carriers for the EEPROM and expander access block
// Assumes: 32-bit register port with 12-bit byte addresses
// Notes: Interrupt register offsets sit in a free area above the expander control
package seia_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] SEIA_OFS_EE_CMD = 12'h34c;
	localparam logic [11:0] SEIA_OFS_IOE_CTL = 12'h350;
	localparam logic [11:0] SEIA_OFS_IRQ_STAT = 12'h360;
	localparam logic [11:0] SEIA_OFS_IRQ_CLR = 12'h364;
	localparam logic [11:0] SEIA_OFS_IRQ_EN = 12'h368;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SEIA_EE_ADDR_LSB = 0;
	localparam int SEIA_EE_DATA_LSB = 16;
	localparam int SEIA_EE_BUSY_BIT = 24;
	localparam int SEIA_EE_DONE_BIT = 25;
	localparam int SEIA_EE_OP_BIT = 26;
	localparam int SEIA_IOE_PIN_LSB = 0;
	localparam int SEIA_IOE_REFRESH_BIT = 24;
	localparam int SEIA_IOE_TEST_BIT = 25;
	localparam int SEIA_IOE_SEL_LSB = 26;
	localparam int SEIA_IOE_DONE_BIT = 31;
	localparam int SEIA_IRQ_EE_BIT = 0;
	localparam int SEIA_IRQ_IOE_BIT = 1;

	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic SEIA_OP_WRITE = 1'h0;
	localparam logic SEIA_OP_READ = 1'h1;
	localparam logic [3:0] SEIA_SEL_IOE0 = 4'h0;
	localparam logic [3:0] SEIA_SEL_IOE1 = 4'h1;
	localparam logic [3:0] SEIA_SEL_IOE2 = 4'h2;
	localparam logic [3:0] SEIA_SEL_IOE4 = 4'h4;
	localparam int SEIA_NUM_IOE = 4;
	localparam logic [15:0] SEIA_RST_EE_ADDR = 16'h0000;
	localparam logic [7:0] SEIA_RST_EE_DATA = 8'h00;
	localparam logic [15:0] SEIA_RST_PINS = 16'h0000;
	localparam logic [3:0] SEIA_RST_SEL = 4'h0;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} seia_ee_cmd_t;

	typedef struct packed {
		logic [1:0] idx;
		logic [15:0] outv;
	} seia_ioe_cmd_t;

endpackage

// File: seia_top.sv
// Purpose: Software access to a serial EEPROM and I/O expanders on the master SMBus
// Assumes: An SMBus engine outside takes one request at a time and pulses its done
// Notes: Requests are levels held until the matching done pulse
//
// Summary of operation
// [R1] 16-bit EEPROM byte address held for next operation
// [R2] Data field write starts one EEPROM operation
// [R3] Write operation stores written byte into EEPROM
// [R4] Read ignores written byte; fetched byte returned
// [R5] Read-only busy flag at bit 24
// [R6] Done flag bit 25, set on finish, W1C
// [R7] Operation select bit 26: zero write, one read
// [R8] Pin field shows last inputs and supplied outputs
// [R9] Pin field writes dropped outside test mode
// [R10] Test mode outputs come from written pin value
// [R11] Input pin bits always read-only
// [R12] Refresh write issues expander SMBus transaction
// [R13] Refresh bit always reads zero
// [R14] Select field 29:26 picks expander, codes 0,1,2,4
// [R15] Bit 25 enables expander test mode
// [R16] Expander done bit 31 set on completion, W1C
// [R17] Busy rises after start, falls with done
// [R18] Software waits idle and clears done first
//
// Implementation choice: the address-and-strobe port.
module seia_top (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rd_data,
	output logic o_irq,
	output logic o_ee_req,
	output seia_pkg::seia_ee_cmd_t o_ee_cmd,
	input wire logic i_ee_done,
	input wire logic [7:0] i_ee_rdata,
	output logic o_ioe_req,
	output seia_pkg::seia_ioe_cmd_t o_ioe_cmd,
	input wire logic i_ioe_done,
	input wire logic [15:0] i_ioe_in_vals,
	input wire logic [15:0] i_ioe_in_mask,
	input wire logic [63:0] i_core_outs
);

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	// Expander select code is one of the four populated slots
	function automatic logic sel_valid(input logic [3:0] code);
		sel_valid = (code == seia_pkg::SEIA_SEL_IOE0) || (code == seia_pkg::SEIA_SEL_IOE1) ||
			(code == seia_pkg::SEIA_SEL_IOE2) || (code == seia_pkg::SEIA_SEL_IOE4);
	endfunction

	// Slot index of a select code; code four lands in the last slot
	function automatic logic [1:0] sel_index(input logic [3:0] code);
		sel_index = (code == seia_pkg::SEIA_SEL_IOE4) ? 2'h3 : code[1:0];
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SEIA_EE_IDLE = 2'b01,
		SEIA_EE_RUN = 2'b10
	} seia_ee_state_t;

	typedef enum logic [1:0] {
		SEIA_IOE_IDLE = 2'b01,
		SEIA_IOE_RUN = 2'b10
	} seia_ioe_state_t;

	seia_ee_state_t ee_state_r;
	seia_ioe_state_t ioe_state_r;
	logic [15:0] ee_addr_r;
	logic [7:0] ee_data_r;
	logic ee_done_r;
	logic ee_op_r;
	logic ioe_test_r;
	logic [3:0] ioe_sel_r;
	logic ioe_done_r;
	logic [15:0] ioe_in_img_r [seia_pkg::SEIA_NUM_IOE];
	logic [15:0] ioe_tm_val_r [seia_pkg::SEIA_NUM_IOE];
	logic [15:0] supplied [seia_pkg::SEIA_NUM_IOE];
	logic [1:0] irq_stat_r;
	logic [1:0] irq_en_r;
	logic wr_ee;
	logic wr_ioe;
	logic wr_clr;
	logic ee_start;
	logic ee_finish;
	logic ioe_finish;
	logic ioe_start;
	logic pin_wr;
	logic [1:0] cur_idx;
	logic cur_ok;
	logic [1:0] wr_idx;
	logic wr_ok;
	logic [15:0] pin_view;
	logic [31:0] rd_nxt;

	// ----------------------------------------------------------------
	// Write decode and events
	// ----------------------------------------------------------------
	// Strobes qualified by address
	assign wr_ee = i_wr && (i_addr == seia_pkg::SEIA_OFS_EE_CMD);
	assign wr_ioe = i_wr && (i_addr == seia_pkg::SEIA_OFS_IOE_CTL);
	assign wr_clr = i_wr && (i_addr == seia_pkg::SEIA_OFS_IRQ_CLR);
	assign cur_idx = sel_index(ioe_sel_r);
	assign cur_ok = sel_valid(ioe_sel_r);
	// A write acts on the expander that it selects itself
	assign wr_idx = sel_index(i_wdata[seia_pkg::SEIA_IOE_SEL_LSB +: 4]); // [R14]
	assign wr_ok = sel_valid(i_wdata[seia_pkg::SEIA_IOE_SEL_LSB +: 4]); // [R14]

	// A data field write starts an operation only when the interface is idle
	assign ee_start = wr_ee && (ee_state_r == SEIA_EE_IDLE); // [R2] [R18]
	assign ee_finish = (ee_state_r == SEIA_EE_RUN) && i_ee_done;

	// Pin field writes only take effect in test mode on a populated slot
	assign pin_wr = wr_ioe && ioe_test_r && wr_ok; // [R9] [R14]
	assign ioe_start = wr_ioe && wr_ok && (ioe_state_r == SEIA_IOE_IDLE) &&
		(i_wdata[seia_pkg::SEIA_IOE_REFRESH_BIT] || pin_wr); // [R12]
	assign ioe_finish = (ioe_state_r == SEIA_IOE_RUN) && i_ioe_done;

	// ----------------------------------------------------------------
	// Output values supplied to each expander
	// ----------------------------------------------------------------
	generate
		for (genvar g = 0; g < seia_pkg::SEIA_NUM_IOE; g++) begin : g_sup
			// Test mode replaces the core-driven outputs
			assign supplied[g] = ioe_test_r ? ioe_tm_val_r[g] : i_core_outs[g*16 +: 16]; // [R10]
		end
	endgenerate

	// Inputs from the last transaction, outputs as currently supplied
	assign pin_view = cur_ok ? ((ioe_in_img_r[cur_idx] & i_ioe_in_mask) |
		(supplied[cur_idx] & ~i_ioe_in_mask)) : seia_pkg::SEIA_RST_PINS; // [R8]

	// ----------------------------------------------------------------
	// EEPROM interface
	// ----------------------------------------------------------------
	// EEPROM sequencer
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ee_state_r <= SEIA_EE_IDLE;
		end else begin
			unique case (ee_state_r)
				SEIA_EE_IDLE: begin
					if (ee_start) begin
						ee_state_r <= SEIA_EE_RUN;
					end
				end
				SEIA_EE_RUN: begin
					if (i_ee_done) begin
						ee_state_r <= SEIA_EE_IDLE;
					end
				end
				default: ee_state_r <= SEIA_EE_IDLE;
			endcase
		end
	end

	// Address, operation and data fields
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ee_addr_r <= seia_pkg::SEIA_RST_EE_ADDR;
			ee_data_r <= seia_pkg::SEIA_RST_EE_DATA;
			ee_op_r <= seia_pkg::SEIA_OP_WRITE;
		end else if (ee_start) begin
			ee_addr_r <= i_wdata[seia_pkg::SEIA_EE_ADDR_LSB +: 16]; // [R1]
			ee_op_r <= i_wdata[seia_pkg::SEIA_EE_OP_BIT]; // [R7]
			if (i_wdata[seia_pkg::SEIA_EE_OP_BIT] == seia_pkg::SEIA_OP_WRITE) begin
				ee_data_r <= i_wdata[seia_pkg::SEIA_EE_DATA_LSB +: 8]; // [R3]
			end
		end else if (ee_finish && (ee_op_r == seia_pkg::SEIA_OP_READ)) begin
			ee_data_r <= i_ee_rdata; // [R4]
		end
	end

	// Done flag; a completion beats a same-cycle clear, busy is the run state
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ee_done_r <= 1'b0;
		end else begin
			if (ee_finish) begin
				ee_done_r <= 1'b1; // [R6]
			end else if (wr_ee && i_wdata[seia_pkg::SEIA_EE_DONE_BIT]) begin
				ee_done_r <= 1'b0; // [R6]
			end
		end
	end

	// Request to the SMBus engine, held until its done pulse
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_ee_req <= 1'b0;
			o_ee_cmd <= '0;
		end else if (ee_start) begin
			o_ee_req <= 1'b1;
			o_ee_cmd.rd <= i_wdata[seia_pkg::SEIA_EE_OP_BIT]; // [R7]
			o_ee_cmd.addr <= i_wdata[seia_pkg::SEIA_EE_ADDR_LSB +: 16]; // [R1]
			o_ee_cmd.wdata <= i_wdata[seia_pkg::SEIA_EE_DATA_LSB +: 8]; // [R3]
		end else if (ee_finish) begin
			o_ee_req <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Expander interface
	// ----------------------------------------------------------------
	// Control fields of the expander register
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ioe_test_r <= 1'b0;
			ioe_sel_r <= seia_pkg::SEIA_RST_SEL;
		end else if (wr_ioe) begin
			ioe_test_r <= i_wdata[seia_pkg::SEIA_IOE_TEST_BIT]; // [R15]
			ioe_sel_r <= i_wdata[seia_pkg::SEIA_IOE_SEL_LSB +: 4]; // [R14]
		end
	end

	// Test values keep only output bits of the written pin field
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			for (int k = 0; k < seia_pkg::SEIA_NUM_IOE; k++) begin
				ioe_tm_val_r[k] <= seia_pkg::SEIA_RST_PINS;
			end
		end else if (pin_wr) begin
			ioe_tm_val_r[wr_idx] <= i_wdata[seia_pkg::SEIA_IOE_PIN_LSB +: 16] &
				~i_ioe_in_mask; // [R10] [R11]
		end
	end

	// Expander sequencer
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ioe_state_r <= SEIA_IOE_IDLE;
		end else begin
			unique case (ioe_state_r)
				SEIA_IOE_IDLE: begin
					if (ioe_start) begin
						ioe_state_r <= SEIA_IOE_RUN;
					end
				end
				SEIA_IOE_RUN: begin
					if (i_ioe_done) begin
						ioe_state_r <= SEIA_IOE_IDLE;
					end
				end
				default: ioe_state_r <= SEIA_IOE_IDLE;
			endcase
		end
	end

	// Request with the outputs to drive; a pin write sends the new value
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_ioe_req <= 1'b0;
			o_ioe_cmd <= '0;
		end else if (ioe_start) begin
			o_ioe_req <= 1'b1; // [R12]
			o_ioe_cmd.idx <= wr_idx; // [R14]
			o_ioe_cmd.outv <= pin_wr ? (i_wdata[seia_pkg::SEIA_IOE_PIN_LSB +: 16] &
				~i_ioe_in_mask) : supplied[wr_idx]; // [R10]
		end else if (ioe_finish) begin
			o_ioe_req <= 1'b0;
		end
	end

	// Input image captured at the end of each transaction
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			for (int k = 0; k < seia_pkg::SEIA_NUM_IOE; k++) begin
				ioe_in_img_r[k] <= seia_pkg::SEIA_RST_PINS;
			end
		end else if (ioe_finish) begin
			ioe_in_img_r[o_ioe_cmd.idx] <= i_ioe_in_vals & i_ioe_in_mask; // [R8] [R12]
		end
	end

	// Expander done flag; completion beats a same-cycle clear
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ioe_done_r <= 1'b0;
		end else if (ioe_finish) begin
			ioe_done_r <= 1'b1; // [R16]
		end else if (wr_ioe && i_wdata[seia_pkg::SEIA_IOE_DONE_BIT]) begin
			ioe_done_r <= 1'b0; // [R16]
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	// Sticky status, write-one clear register, set wins
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			irq_stat_r <= 2'h0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if ((k == seia_pkg::SEIA_IRQ_EE_BIT) ? ee_finish : ioe_finish) begin
					irq_stat_r[k] <= 1'b1;
				end else if (wr_clr && i_wdata[k]) begin
					irq_stat_r[k] <= 1'b0;
				end
			end
		end
	end

	// Enable register and level interrupt output
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			irq_en_r <= 2'h0;
			o_irq <= 1'b0;
		end else begin
			if (i_wr && (i_addr == seia_pkg::SEIA_OFS_IRQ_EN)) begin
				irq_en_r <= i_wdata[1:0];
			end
			o_irq <= |(irq_stat_r & irq_en_r);
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Read mux; refresh bit and reserved bits read as zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (i_rd) begin
			unique case (i_addr)
				seia_pkg::SEIA_OFS_EE_CMD: begin
					rd_nxt[seia_pkg::SEIA_EE_ADDR_LSB +: 16] = ee_addr_r;
					rd_nxt[seia_pkg::SEIA_EE_DATA_LSB +: 8] = ee_data_r; // [R4]
					rd_nxt[seia_pkg::SEIA_EE_BUSY_BIT] = (ee_state_r == SEIA_EE_RUN); // [R5] [R17]
					rd_nxt[seia_pkg::SEIA_EE_DONE_BIT] = ee_done_r;
					rd_nxt[seia_pkg::SEIA_EE_OP_BIT] = ee_op_r;
				end
				seia_pkg::SEIA_OFS_IOE_CTL: begin
					rd_nxt[seia_pkg::SEIA_IOE_PIN_LSB +: 16] = pin_view; // [R8]
					rd_nxt[seia_pkg::SEIA_IOE_REFRESH_BIT] = 1'b0; // [R13]
					rd_nxt[seia_pkg::SEIA_IOE_TEST_BIT] = ioe_test_r;
					rd_nxt[seia_pkg::SEIA_IOE_SEL_LSB +: 4] = ioe_sel_r;
					rd_nxt[seia_pkg::SEIA_IOE_DONE_BIT] = ioe_done_r;
				end
				seia_pkg::SEIA_OFS_IRQ_STAT: rd_nxt[1:0] = irq_stat_r;
				seia_pkg::SEIA_OFS_IRQ_EN: rd_nxt[1:0] = irq_en_r;
				default: rd_nxt = 32'h0000_0000;
			endcase
		end
	end

	// Read data stands for the one cycle after the strobe
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rd_data <= 32'h0000_0000;
		end else begin
			o_rd_data <= rd_nxt;
		end
	end

endmodule

// File: seia_chk.sv
// Purpose: Port assertions for the EEPROM and expander access block
// Assumes: One clock, reset active high
// Notes: Bound to every seia_top instance
module seia_chk (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rd_data,
	input wire logic o_irq,
	input wire logic o_ee_req,
	input wire seia_pkg::seia_ee_cmd_t o_ee_cmd,
	input wire logic i_ee_done,
	input wire logic [7:0] i_ee_rdata,
	input wire logic o_ioe_req,
	input wire seia_pkg::seia_ioe_cmd_t o_ioe_cmd,
	input wire logic i_ioe_done,
	input wire logic [15:0] i_ioe_in_vals,
	input wire logic [15:0] i_ioe_in_mask,
	input wire logic [63:0] i_core_outs
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	logic ee_wr;
	logic ioe_wr;
	logic sel_ok;
	// Decoded writes and select validity
	assign ee_wr = i_wr && (i_addr == seia_pkg::SEIA_OFS_EE_CMD);
	assign ioe_wr = i_wr && (i_addr == seia_pkg::SEIA_OFS_IOE_CTL);
	assign sel_ok = i_wdata[29:26] inside {4'h0, 4'h1, 4'h2, 4'h4};
	// EEPROM request life cycle
	a_ee_start_cause: assert property ($rose(o_ee_req) |-> $past(ee_wr))
		else $error("EEPROM request without data write");
	a_ee_busy_hold: assert property (o_ee_req && !i_ee_done |=> o_ee_req)
		else $error("EEPROM request dropped early");
	a_ee_busy_drop: assert property (o_ee_req && i_ee_done |=> !o_ee_req)
		else $error("EEPROM request kept after done");
	a_ee_cmd_stable: assert property (o_ee_req && $past(o_ee_req) |-> $stable(o_ee_cmd))
		else $error("EEPROM command moved while busy");
	a_ee_wr_cmd: assert property (ee_wr && !o_ee_req && !i_wdata[26] |=> o_ee_req
		&& !o_ee_cmd.rd && o_ee_cmd.wdata == $past(i_wdata[23:16])
		&& o_ee_cmd.addr == $past(i_wdata[15:0]))
		else $error("EEPROM write command wrong");
	a_ee_rd_cmd: assert property (ee_wr && !o_ee_req && i_wdata[26] |=> o_ee_cmd.rd)
		else $error("EEPROM read not selected");
	// Expander transaction life cycle
	a_ioe_start_cause: assert property ($rose(o_ioe_req) |-> $past(ioe_wr))
		else $error("Expander request without write");
	a_refresh_go: assert property (ioe_wr && i_wdata[24] && sel_ok && !o_ioe_req
		|=> o_ioe_req)
		else $error("Refresh did not start");
	a_ioe_drop: assert property (o_ioe_req && i_ioe_done |=> !o_ioe_req)
		else $error("Expander request kept after done");
	a_bad_sel_idle: assert property (ioe_wr && !sel_ok && !o_ioe_req |=> !o_ioe_req)
		else $error("Reserved select started a transaction");
	a_refresh_zero: assert property (i_rd && i_addr == seia_pkg::SEIA_OFS_IOE_CTL
		|=> !o_rd_data[24])
		else $error("Refresh bit read as one");
	c_ee_read: cover property (o_ee_req && o_ee_cmd.rd && i_ee_done);
	c_ioe_done: cover property (o_ioe_req && i_ioe_done);
	c_irq: cover property ($rose(o_irq));
endmodule
bind seia_top seia_chk chk_u (.i_ref_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
	.o_rd_data, .o_irq, .o_ee_req, .o_ee_cmd, .i_ee_done, .i_ee_rdata, .o_ioe_req,
	.o_ioe_cmd, .i_ioe_done, .i_ioe_in_vals, .i_ioe_in_mask, .i_core_outs);

// File: seia_far.sv
// Purpose: Behavioural EEPROM and expander engine on the far side
// Assumes: Requests are levels held until the done pulse
// Notes: EEPROM answers slow then prompt by turns
module seia_far #(
	parameter logic [15:0] IN_BASE = 16'hc3a5
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_ee_req,
	input wire seia_pkg::seia_ee_cmd_t i_ee_cmd,
	input wire logic i_ioe_req,
	input wire seia_pkg::seia_ioe_cmd_t i_ioe_cmd,
	output logic o_ee_done,
	output logic [7:0] o_ee_rdata,
	output logic o_ioe_done,
	output logic [15:0] o_ioe_in_vals
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem_r [256];
	logic [3:0] ee_cnt_r;
	logic [3:0] ioe_cnt_r;
	logic slow_r;
	// EEPROM store; read data toggles outside the done cycle
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ee_cnt_r <= 4'h0;
			o_ee_done <= 1'h0;
			o_ee_rdata <= 8'h00;
			slow_r <= 1'h1;
		end else if (i_ee_req && !o_ee_done) begin
			ee_cnt_r <= ee_cnt_r + 4'h1;
			o_ee_rdata <= ~o_ee_rdata;
			if (ee_cnt_r == (slow_r ? 4'hb : 4'h2)) begin
				o_ee_done <= 1'h1;
				o_ee_rdata <= mem_r[i_ee_cmd.addr[7:0]];
				if (!i_ee_cmd.rd)
					mem_r[i_ee_cmd.addr[7:0]] <= i_ee_cmd.wdata;
			end
		end else begin
			ee_cnt_r <= 4'h0;
			o_ee_done <= 1'h0;
			o_ee_rdata <= ~o_ee_rdata;
			if (o_ee_done)
				slow_r <= ~slow_r;
		end
	end
	// Expander answers after five cycles with per-slot inputs
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ioe_cnt_r <= 4'h0;
			o_ioe_done <= 1'h0;
			o_ioe_in_vals <= 16'h0000;
		end else if (i_ioe_req && !o_ioe_done) begin
			ioe_cnt_r <= ioe_cnt_r + 4'h1;
			o_ioe_in_vals <= ~o_ioe_in_vals;
			if (ioe_cnt_r == 4'h4) begin
				o_ioe_done <= 1'h1;
				o_ioe_in_vals <= IN_BASE + 16'(i_ioe_cmd.idx);
			end
		end else begin
			ioe_cnt_r <= 4'h0;
			o_ioe_done <= 1'h0;
			o_ioe_in_vals <= ~o_ioe_in_vals;
		end
	end
endmodule

// File: test_smbus_eeprom_ioexp_access.sv
// Purpose: Register-level tests of the EEPROM and expander access block
// Assumes: Far side model answers every request
// Notes: Lower pin byte is wired as expander inputs
module test_smbus_eeprom_ioexp_access;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] IN_BASE = 16'hc3a5;
	localparam logic [15:0] IN_MASK = 16'h00ff;
	localparam logic [63:0] CORE = 64'h4c4c_3b3b_2a2a_1919;
	logic i_ref_clk = 1'h0;
	logic i_sys_rst = 1'h1;
	logic [11:0] i_addr = 12'h000;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'h0;
	logic i_rd = 1'h0;
	logic [31:0] o_rd_data;
	logic o_irq, o_ee_req, i_ee_done, o_ioe_req, i_ioe_done;
	seia_pkg::seia_ee_cmd_t o_ee_cmd;
	seia_pkg::seia_ioe_cmd_t o_ioe_cmd;
	logic [7:0] i_ee_rdata;
	logic [15:0] i_ioe_in_vals;
	logic [31:0] rdv;
	logic [3:0] sel;
	logic [15:0] pins;
	int err_count = 0;
	int cmp_count = 0;
	// Free-running 50 MHz clock
	always #10 i_ref_clk = ~i_ref_clk;
	seia_top dut_u (.i_ref_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rd_data,
		.o_irq, .o_ee_req, .o_ee_cmd, .i_ee_done, .i_ee_rdata, .o_ioe_req, .o_ioe_cmd,
		.i_ioe_done, .i_ioe_in_vals, .i_ioe_in_mask(IN_MASK), .i_core_outs(CORE));
	seia_far #(.IN_BASE(IN_BASE)) far_u (.i_ref_clk, .i_sys_rst, .i_ee_req(o_ee_req),
		.i_ee_cmd(o_ee_cmd), .i_ioe_req(o_ioe_req), .i_ioe_cmd(o_ioe_cmd),
		.o_ee_done(i_ee_done), .o_ee_rdata(i_ee_rdata), .o_ioe_done(i_ioe_done),
		.o_ioe_in_vals(i_ioe_in_vals));
	task automatic complete_run();
		$display("Checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'h1;
		@(posedge i_ref_clk);
		i_wr <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'h1;
		@(posedge i_ref_clk);
		i_rd <= 1'h0;
		#1;
		d = o_rd_data;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
		rd(a, rdv);
		check(name, rdv, exp);
	endtask
	// Software polls a status bit, bounded
	task automatic poll(input logic [11:0] a, input int b);
		for (int n = 0; n < 40; n++) begin
			rd(a, rdv);
			if (rdv[b] === 1'h1)
				return;
		end
		err_count++;
		$display("Error poll %h timed out", a);
		complete_run();
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge i_ref_clk);
		i_sys_rst <= 1'h0;
		rd_chk("ee reg", 12'h34c, 32'h0);
		rd_chk("irq stat", 12'h360, 32'h0);
		rd_chk("unmapped", 12'h3fc, 32'h0);
		$display("Test reset done");
		wr(12'h368, 32'h1);
		wr(12'h34c, 32'h005a0012);
		rd_chk("ee busy", 12'h34c, 32'h015a0012);
		wr(12'h34c, 32'h00110034);
		poll(12'h34c, 25);
		rd_chk("ee write", 12'h34c, 32'h025a0012);
		check("irq on", {31'h0, o_irq}, 32'h1);
		wr(12'h364, 32'h1);
		@(posedge i_ref_clk);
		#1;
		check("irq off", {31'h0, o_irq}, 32'h0);
		wr(12'h368, 32'h0);
		wr(12'h34c, 32'h06ff0012);
		poll(12'h34c, 25);
		rd_chk("ee read", 12'h34c, 32'h065a0012);
		check("irq masked", {31'h0, o_irq}, 32'h0);
		rd_chk("irq stat", 12'h360, 32'h1);
		wr(12'h364, 32'h1);
		$display("Test eeprom done");
		wr(12'h368, 32'h2);
		for (int k = 0; k < 4; k++) begin
			sel = (k == 3) ? 4'h4 : 4'(k);
			pins = ((IN_BASE + 16'(k)) & IN_MASK) | (CORE[16*k +: 16] & ~IN_MASK);
			wr(12'h350, {2'h0, sel, 2'h1, 24'h0});
			#1;
			check("ioe cmd", {14'h0, o_ioe_cmd}, {14'h0, 2'(k), CORE[16*k +: 16]});
			poll(12'h350, 31);
			rd_chk("pins", 12'h350, {2'h2, sel, 10'h0, pins});
			check("irq ioe", {31'h0, o_irq}, 32'h1);
			wr(12'h364, 32'h2);
			wr(12'h350, {2'h2, sel, 10'h0, 16'hffff});
			rd_chk("pins kept", 12'h350, {2'h0, sel, 10'h0, pins});
		end
		$display("Test refresh done");
		wr(12'h350, 32'h0d000000);
		repeat (3) @(posedge i_ref_clk);
		#1;
		check("no req", {31'h0, o_ioe_req}, 32'h0);
		rd_chk("rsvd sel", 12'h350, 32'h0c000000);
		wr(12'h350, 32'h02000000);
		wr(12'h350, 32'h0200abcd);
		#1;
		check("test outv", {16'h0, o_ioe_cmd.outv}, 32'h0000ab00);
		poll(12'h350, 31);
		pins = (IN_BASE & IN_MASK) | (16'habcd & ~IN_MASK);
		rd_chk("test pins", 12'h350, {16'h8200, pins});
		$display("Test expander mode done");
		complete_run();
	end
endmodule
